//--- design/asc_pkg.sv
// Package for the converter sample and convert control block.
// Assumes one clock domain; the clock enable stands for the conversion clock rate.
package asc_pkg;
   localparam int  ASC_ADDR_W   = 4;
   localparam int  ASC_DATA_W   = 16;
   localparam int  ASC_NUM_CH   = 12;
   localparam int  ASC_NUM_PIN  = 8;
   localparam int  ASC_CH_W     = 4;
   localparam int  ASC_CNT_W    = 7;
   // Register offsets.
   localparam logic [3:0] ASC_REG_CTRL   = 4'h0;
   localparam logic [3:0] ASC_REG_REF    = 4'h1;
   localparam logic [3:0] ASC_REG_CHAN   = 4'h2;
   localparam logic [3:0] ASC_REG_AE     = 4'h3;
   localparam logic [3:0] ASC_REG_STATUS = 4'h4;
   // Control register fields.
   localparam int CTL_ENABLE  = 0;
   localparam int CTL_CORE_ON = 1;
   localparam int CTL_SWSTART = 2;
   localparam int CTL_INVERT  = 3;
   localparam int CTL_SRC_LO  = 4;
   localparam int CTL_SHT_LO  = 6;
   // Reference register fields.
   localparam int REF_POWER   = 0;
   localparam int REF_LEVEL   = 1;
   localparam int REF_OUT     = 2;
   localparam int REF_BURST   = 3;
   localparam int REF_LOWRATE = 4;
   localparam int REF_EXT_HI  = 5;
   localparam int REF_EXT_LO  = 6;
   // Trigger sources.
   localparam logic [1:0] ASC_SRC_SW  = 2'h0;
   localparam logic [1:0] ASC_SRC_T1  = 2'h1;
   localparam logic [1:0] ASC_SRC_T0  = 2'h2;
   localparam logic [1:0] ASC_SRC_T2  = 2'h3;
   // Timing in conversion-clock cycles.
   localparam logic [6:0] ASC_SHT_4   = 7'h04;
   localparam logic [6:0] ASC_SHT_8   = 7'h08;
   localparam logic [6:0] ASC_SHT_16  = 7'h10;
   localparam logic [6:0] ASC_SHT_64  = 7'h40;
   localparam logic [6:0] ASC_CONV_CYC = 7'h0D;
   localparam logic [6:0] ASC_ONE     = 7'h01;
   localparam logic [15:0] ASC_ZERO16 = 16'h0000;
   typedef enum logic [1:0] {
      ASC_IDLE   = 2'b00,
      ASC_SYNC   = 2'b01,
      ASC_SAMPLE = 2'b11,
      ASC_CONV   = 2'b10
   } asc_state_t;
endpackage

//--- design/asc_sync.sv
// Two-stage synchroniser for a single level input.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/10ps
`default_nettype none
module asc_sync (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   // Level in and out
   input  wire logic din,
   output var  logic dout
);
   logic stage1;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stage1 <= 1'b0;
         dout   <= 1'b0;
      end else if (ce) begin
         stage1 <= din;
         dout   <= stage1;
      end
   end
endmodule
`default_nettype wire

//--- design/asc_mux_switch.sv
// One T-switch of the input multiplexer: break-before-make control.
// Assumes the select and sample request come from logic synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module asc_mux_switch (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   // Control
   input  wire logic want,
   input  wire logic others_closed,
   // Switch drive
   output var  logic closed,
   output var  logic ground
);
   // A switch may close only once every other switch has opened.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         closed <= 1'b0;
         ground <= 1'b1;
      end else if (ce) begin
         closed <= want & ~others_closed;
         ground <= ~(want & ~others_closed);
      end
   end
endmodule
`default_nettype wire

//--- design/asc_ctrl.sv
// Sample and convert control: trigger select, sample timer, conversion timer,
// multiplexer switching, pin analog enables and reference controls.
// Assumes ce pulses once per conversion-clock cycle and all inputs are synchronous.
//
// Behaviour
// - A rising edge on the sample trigger starts a conversion cycle.
// - Trigger source is software bit or timer outputs 1, 0, 2.
// - Trigger invert flips the chosen source before edge detection.
// - Sample period is 4, 8, 16 or 64 conversion-clock cycles.
// - Trigger synchronised first, then sampling held high for the period.
// - Falling edge of sampling starts a 13-cycle conversion.
// - Inputs disconnected unless sampling; then only the selected one connects.
// - Multiplexer opens the old switch before closing the new one.
// - Unselected channels isolated with intermediate node grounded.
// - Channel select covers eight external and four internal inputs.
// - One analog-enable bit per pin disables its digital buffers.
// - Reference generator powered only while reference power bit is 1.
// - Reference level 2.5 V when level bit is 1, else 1.5 V.
// - Output plus burst drives reference only in sample and conversion.
// - Low-rate bit puts reference buffer in reduced-current mode.
// - External upper reference from A4, lower from A3 when chosen.
// - No conversion unless conversion enable is 1.
// - Core powered only while core power bit is set.
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module asc_ctrl (
   // Clock and reset
   input  wire logic                            clk,
   input  wire logic                            rst,
   input  wire logic                            ce,
   // Register port
   input  wire logic [asc_pkg::ASC_ADDR_W-1:0]  addr,
   input  wire logic [asc_pkg::ASC_DATA_W-1:0]  wdata,
   input  wire logic                            wr,
   input  wire logic                            rd,
   output var  logic [asc_pkg::ASC_DATA_W-1:0]  rdata,
   // Timer trigger outputs
   input  wire logic                            timer_out0,
   input  wire logic                            timer_out1,
   input  wire logic                            timer_out2,
   // Converter and analog controls
   output var  logic                            sampling_active,
   output var  logic                            converting,
   output var  logic                            core_power_on,
   output var  logic [asc_pkg::ASC_NUM_CH-1:0]  switch_closed,
   output var  logic [asc_pkg::ASC_NUM_CH-1:0]  node_ground,
   output var  logic [asc_pkg::ASC_NUM_PIN-1:0] analog_pin_enable,
   output var  logic                            ref_power_on,
   output var  logic                            ref_level_select,
   output var  logic                            ref_drive_external,
   output var  logic                            low_rate_buffer_mode,
   output var  logic                            ext_ref_hi_a4,
   output var  logic                            ext_ref_lo_a3
);
   import asc_pkg::*;

   typedef struct packed {
      logic [15:0]          ctrl;
      logic [15:0]          refc;
      logic [ASC_CH_W-1:0]  chan;
      logic [7:0]           ae;
      logic                 trig_prev;
      asc_state_t           state;
      logic [ASC_CNT_W-1:0] cnt;
      logic [15:0]          rdata;
      logic                 refdrv;
      logic                 samp;
      logic                 conv;
   } asc_regs_t;

   asc_regs_t r;
   asc_regs_t next_r;

   logic                sel_src;
   logic                trig_raw;
   logic                trig_sync;
   logic                trig_edge;
   logic [ASC_CNT_W-1:0] sht_len;
   logic [ASC_NUM_CH-1:0] want;
   logic [ASC_NUM_CH-1:0] closed_w;
   logic [ASC_NUM_CH-1:0] ground_w;

   ////////////////////////////////////////////////////////////////////////////
   // Trigger path.
   always_comb begin
      case (r.ctrl[CTL_SRC_LO +: 2])
         ASC_SRC_SW: sel_src = r.ctrl[CTL_SWSTART];
         ASC_SRC_T1: sel_src = timer_out1;
         ASC_SRC_T0: sel_src = timer_out0;
         ASC_SRC_T2: sel_src = timer_out2;
         default:    sel_src = 1'b0;
      endcase
      trig_raw = sel_src ^ r.ctrl[CTL_INVERT];
   end

   // Synchroniser output is the second stage; the edge detector only sees it.
   asc_sync u_sync (
      .clk  (clk),
      .rst  (rst),
      .ce   (ce),
      .din  (trig_raw),
      .dout (trig_sync)
   );

   assign trig_edge = trig_sync & ~r.trig_prev;

   always_comb begin
      case (r.ctrl[CTL_SHT_LO +: 2])
         2'h0:    sht_len = ASC_SHT_4;
         2'h1:    sht_len = ASC_SHT_8;
         2'h2:    sht_len = ASC_SHT_16;
         2'h3:    sht_len = ASC_SHT_64;
         default: sht_len = ASC_SHT_4;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state.
   always_comb begin
      next_r = r;
      next_r.trig_prev = trig_sync;
      next_r.rdata = ASC_ZERO16;
      if (wr) begin
         case (addr)
            ASC_REG_CTRL: next_r.ctrl = wdata;
            ASC_REG_REF:  next_r.refc = wdata;
            ASC_REG_CHAN: next_r.chan = (wdata[ASC_CH_W-1:0] < ASC_CH_W'(ASC_NUM_CH)) ?
                                        wdata[ASC_CH_W-1:0] : r.chan;
            ASC_REG_AE:   next_r.ae = wdata[7:0];
            default:      next_r = next_r;
         endcase
      end
      if (rd) begin
         case (addr)
            ASC_REG_CTRL:   next_r.rdata = r.ctrl;
            ASC_REG_REF:    next_r.rdata = r.refc;
            ASC_REG_CHAN:   next_r.rdata = {12'h000, r.chan};
            ASC_REG_AE:     next_r.rdata = {8'h00, r.ae};
            ASC_REG_STATUS: next_r.rdata = {12'h000, r.state, (r.state == ASC_CONV),
                                            (r.state == ASC_SAMPLE)};
            default:        next_r.rdata = ASC_ZERO16;
         endcase
      end
      if (ce) begin
         case (r.state)
            ASC_IDLE: begin
               // The edge is already synchronised, so sampling rises on the next enabled clock edge.
               if (trig_edge && r.ctrl[CTL_ENABLE] && r.ctrl[CTL_CORE_ON]) begin
                  next_r.state = ASC_SAMPLE;
                  next_r.cnt   = sht_len - ASC_ONE;
               end
            end
            ASC_SYNC:
               next_r.state = ASC_IDLE;
            ASC_SAMPLE: begin
               if (r.cnt == '0) begin
                  next_r.state = ASC_CONV;
                  next_r.cnt   = ASC_CONV_CYC - ASC_ONE;
               end else begin
                  next_r.cnt = r.cnt - ASC_ONE;
               end
            end
            ASC_CONV: begin
               if (r.cnt == '0) next_r.state = ASC_IDLE;
               else next_r.cnt = r.cnt - ASC_ONE;
            end
            default: next_r.state = ASC_IDLE;
         endcase
         if (!r.ctrl[CTL_CORE_ON]) next_r.state = ASC_IDLE;
      end
      // Burst drive is registered with the state and the new reference setting,
      // so it never lags a write to the reference controls by a cycle.
      next_r.refdrv = next_r.refc[REF_OUT] &
                      (~next_r.refc[REF_BURST] | (next_r.state == ASC_SAMPLE) |
                       (next_r.state == ASC_CONV));
      next_r.samp   = (next_r.state == ASC_SAMPLE);
      next_r.conv   = (next_r.state == ASC_CONV);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r <= '0;
      end else if (ce || wr || rd) begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Multiplexer switches.
   // The switches look at the next state, so they open on the same edge as sampling ends
   // and no input stays connected into the conversion.
   always_comb begin
      for (int i = 0; i < ASC_NUM_CH; i++) begin
         want[i] = (next_r.state == ASC_SAMPLE) && (next_r.chan == ASC_CH_W'(i));
      end
   end

   for (genvar g = 0; g < ASC_NUM_CH; g++) begin : g_sw
      asc_mux_switch u_sw (
         .clk           (clk),
         .rst           (rst),
         .ce            (ce),
         .want          (want[g]),
         .others_closed (|(closed_w & ~(ASC_NUM_CH'(1) << g))),
         .closed        (closed_w[g]),
         .ground        (ground_w[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all from flip-flops.
   always_comb begin
      rdata                = r.rdata;
      sampling_active      = r.samp;
      converting           = r.conv;
      core_power_on        = r.ctrl[CTL_CORE_ON];
      switch_closed        = closed_w;
      node_ground          = ground_w;
      analog_pin_enable    = r.ae;
      ref_power_on         = r.refc[REF_POWER];
      ref_level_select     = r.refc[REF_LEVEL];
      ref_drive_external   = r.refdrv;
      low_rate_buffer_mode = r.refc[REF_LOWRATE];
      ext_ref_hi_a4        = r.refc[REF_EXT_HI];
      ext_ref_lo_a3        = r.refc[REF_EXT_LO];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   property p_no_start_disabled;
      @(posedge clk) disable iff (rst)
      (ce && r.state == ASC_IDLE && !r.ctrl[CTL_ENABLE]) |=> (r.state == ASC_IDLE);
   endproperty
   a_no_start_disabled: assert property (p_no_start_disabled) else $error("start while disabled");

   property p_start_on_edge;
      @(posedge clk) disable iff (rst)
      (ce && r.state == ASC_IDLE && trig_edge && r.ctrl[CTL_ENABLE] && r.ctrl[CTL_CORE_ON])
         |=> (r.state == ASC_SAMPLE);
   endproperty
   a_start_on_edge: assert property (p_start_on_edge) else $error("edge did not start sampling");

   property p_conv_after_sample;
      @(posedge clk) disable iff (rst)
      ($fell(sampling_active) && r.ctrl[CTL_CORE_ON]) |-> converting;
   endproperty
   a_conv_after_sample: assert property (p_conv_after_sample) else $error("no conversion after sample");

   property p_conv_len;
      @(posedge clk) disable iff (rst)
      (ce && r.state == ASC_CONV && r.cnt == '0) |=> (r.state == ASC_IDLE);
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

   property p_one_switch;
      @(posedge clk) disable iff (rst)
      $onehot0(switch_closed);
   endproperty
   a_one_switch: assert property (p_one_switch) else $error("two switches closed");

   property p_isolated;
      @(posedge clk) disable iff (rst)
      !sampling_active |-> (switch_closed == '0);
   endproperty
   a_isolated: assert property (p_isolated) else $error("input connected outside sampling");

   property p_ground;
      @(posedge clk) disable iff (rst)
      (node_ground == ~switch_closed);
   endproperty
   a_ground: assert property (p_ground) else $error("open switch not grounded");

   property p_sample4;
      @(posedge clk) disable iff (rst)
      (ce && r.state == ASC_IDLE && trig_edge && r.ctrl[CTL_ENABLE] && r.ctrl[CTL_CORE_ON]
       && r.ctrl[CTL_SHT_LO +: 2] == 2'h0 && $stable(r.ctrl)) ##1 ce[*4] |=> !sampling_active;
   endproperty
   a_sample4: assert property (p_sample4) else $error("four-cycle sample wrong");

   property p_burst;
      @(posedge clk) disable iff (rst)
      (r.refc[REF_OUT] && r.refc[REF_BURST] && r.state == ASC_IDLE && $past(r.state) == ASC_IDLE)
         |-> !ref_drive_external;
   endproperty
   a_burst: assert property (p_burst) else $error("burst reference driven while idle");

   property p_ref_cont;
      @(posedge clk) disable iff (rst)
      (r.refc[REF_OUT] && !r.refc[REF_BURST]) |-> ref_drive_external;
   endproperty
   a_ref_cont: assert property (p_ref_cont) else $error("continuous reference not driven");

   property p_ref_off;
      @(posedge clk) disable iff (rst)
      !r.refc[REF_OUT] |-> !ref_drive_external;
   endproperty
   a_ref_off: assert property (p_ref_off) else $error("reference driven while output off");

   property p_core_abort;
      @(posedge clk) disable iff (rst)
      (ce && !r.ctrl[CTL_CORE_ON]) |=> (!sampling_active && !converting);
   endproperty
   a_core_abort: assert property (p_core_abort) else $error("activity with core powered down");

   property p_phase_excl;
      @(posedge clk) disable iff (rst)
      !(sampling_active && converting);
   endproperty
   a_phase_excl: assert property (p_phase_excl) else $error("sampling and converting together");
endmodule
`default_nettype wire

//--- tb/asc_timer_model.sv
// Far-side model of the on-chip timer outputs that can trigger a conversion.
// Assumes go pulses arrive one cycle long from the bench, synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module asc_timer_model #(
   parameter int HIGH_CYC = 6
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Command and timer levels
   input  wire logic [2:0] go,
   output var  logic [2:0] tout
);
   int cnt;
   ////////////////////////////////////////////////////////////////
   // A real timer output stays high for a while; one shared count keeps the model small.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tout <= 3'h0;
         cnt  <= 0;
      end else if (go != 3'h0) begin
         tout <= go;
         cnt  <= HIGH_CYC;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else begin
         tout <= 3'h0;
         cnt  <= 0;
      end
   end
endmodule
`default_nettype wire

//--- tb/asc_ctrl_bench.sv
// Self-checking bench for the sample and convert control block.
// Assumes ce held high, so one conversion-clock cycle equals one clk cycle.
`timescale 1ns/10ps
`default_nettype none
module asc_ctrl_bench;
   import asc_pkg::*;
   logic                   clk, rst, ce, wr, rd, snap;
   logic [ASC_ADDR_W-1:0]  addr;
   logic [ASC_DATA_W-1:0]  wdata, rdata;
   logic [2:0]             go, tout;
   logic                   sampling_active, converting, core_power_on, ref_power_on, ref_level_select;
   logic                   ref_drive_external, low_rate_buffer_mode, ext_ref_hi_a4, ext_ref_lo_a3;
   logic [ASC_NUM_CH-1:0]  switch_closed, node_ground;
   logic [ASC_NUM_PIN-1:0] analog_pin_enable;
   int                     mismatches, n_tests, cycles;
   logic [15:0]            exp_rd[$];
   logic [65:0]            exp_cv[$];
   logic [14:0]            exp_pt[$];
   logic [6:0]             sht_len [4];
   asc_ctrl uut (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .timer_out0(tout[0]), .timer_out1(tout[1]), .timer_out2(tout[2]), .sampling_active(sampling_active),
      .converting(converting), .core_power_on(core_power_on), .switch_closed(switch_closed),
      .node_ground(node_ground), .analog_pin_enable(analog_pin_enable), .ref_power_on(ref_power_on),
      .ref_level_select(ref_level_select), .ref_drive_external(ref_drive_external),
      .low_rate_buffer_mode(low_rate_buffer_mode), .ext_ref_hi_a4(ext_ref_hi_a4), .ext_ref_lo_a3(ext_ref_lo_a3));
   asc_timer_model u_tmr (.clk(clk), .rst(rst), .go(go), .tout(tout));
   always #5 clk = ~clk;
   ////////////////////////////////////////////////////////////////
   task complete_run;
      $display("checks %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // A hang in any wait would otherwise stall the run for good.
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 6000) begin
         mismatches = mismatches + 1;
         $display("[ERR] %0t timeout", $time);
         complete_run;
      end
   end
   task automatic chk(input logic [65:0] got, input logic [65:0] exp, input string what);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   function automatic logic [65:0] exp_rec(input logic [6:0] n, input logic [11:0] sw, input logic rs, input logic ri);
      return {1'b0, n, 1'b0, ASC_CONV_CYC, sw, ~sw, rs, ri, 12'h000, 12'hFFF};
   endfunction
   ////////////////////////////////////////////////////////////////
   // Watcher: samples on the falling edge, well clear of the bench's drive edge.
   initial begin : mon
      logic        rd_prev, rs, ri;
      logic [7:0]  sl, cl;
      logic [11:0] sw, ng, swi, ngi;
      rd_prev = 1'b0;
      forever begin
         @(negedge clk);
         if (rd_prev) chk(66'(rdata), 66'(exp_rd.pop_front()), "read");
         if (snap === 1'b1) chk(66'({analog_pin_enable, core_power_on, ref_power_on, ref_level_select, ref_drive_external,
            low_rate_buffer_mode, ext_ref_hi_a4, ext_ref_lo_a3}), 66'(exp_pt.pop_front()), "levels");
         rd_prev = (rd === 1'b1);
         if (sampling_active === 1'b1) begin
            sl = '0;
            cl = '0;
            sw = '0;
            ng = '0;
            rs = 1'b0;
            while (sampling_active === 1'b1) begin
               sl = sl + 8'h01;
               if (sl == 8'h02) begin
                  sw = switch_closed;
                  ng = node_ground;
                  rs = ref_drive_external;
               end
               @(negedge clk);
            end
            while (converting === 1'b1) begin
               cl = cl + 8'h01;
               @(negedge clk);
            end
            repeat (2) @(negedge clk);
            ri  = ref_drive_external;
            swi = switch_closed;
            ngi = node_ground;
            if (exp_cv.size() == 0) chk(66'h1, 66'h0, "unexpected conversion");
            else chk({sl, cl, sw, ng, rs, ri, swi, ngi}, exp_cv.pop_front(), "conversion");
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   task wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      exp_rd.push_back(e);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
   endtask
   task snap_chk(input logic [14:0] e);
      @(posedge clk);
      exp_pt.push_back(e);
      snap <= 1'b1;
      @(posedge clk);
      snap <= 1'b0;
   endtask
   task fire(input int i);
      @(posedge clk);
      go[i] <= 1'b1;
      @(posedge clk);
      go <= 3'h0;
   endtask
   task wait_done;
      for (int i = 0; i < 300 && !(i > 16 && sampling_active === 1'b0 && converting === 1'b0); i++) @(negedge clk);
      repeat (4) @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin : main
      logic [6:0] r;
      logic [7:0] ae;
      logic [3:0] ch;
      logic [1:0] s;
      int         ti;
      clk = 1'b0; rst = 1'b1; ce = 1'b1; wr = 1'b0; rd = 1'b0; snap = 1'b0;
      addr = '0; wdata = '0; go = '0; mismatches = 0; n_tests = 0; cycles = 0;
      sht_len = '{ASC_SHT_4, ASC_SHT_8, ASC_SHT_16, ASC_SHT_64};
      void'($urandom(7));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      snap_chk(15'h0000);
      rd_reg(ASC_REG_STATUS, 16'h0000);
      $display("test reset done");
      ch = 4'($urandom_range(11));
      ae = 8'($urandom_range(255));
      wr_reg(ASC_REG_CHAN, {12'h000, ch});
      wr_reg(ASC_REG_CHAN, 16'h000C);
      rd_reg(ASC_REG_CHAN, {12'h000, ch});
      wr_reg(ASC_REG_AE, {8'h00, ae});
      rd_reg(4'hF, 16'h0000);
      $display("test registers done");
      for (int j = 0; j < 4; j++) begin
         r = 7'($urandom_range(127));
         r[2] = 1'b1;
         r[3] = j[0];
         if (r[5] | r[6]) r[0] = 1'b0;
         wr_reg(ASC_REG_REF, {9'h000, r});
         wr_reg(ASC_REG_CTRL, {8'h00, 2'(j), 6'h03});
         snap_chk({ae, 1'b1, r[0], r[1], r[2] & ~r[3], r[4], r[5], r[6]});
         exp_cv.push_back(exp_rec(sht_len[j], 12'h001 << ch, r[2], r[2] & ~r[3]));
         wr_reg(ASC_REG_CTRL, {8'h00, 2'(j), 6'h07});
         wait_done;
         wr_reg(ASC_REG_CTRL, {8'h00, 2'(j), 6'h03});
      end
      $display("test sample periods done");
      for (int j = 1; j < 4; j++) begin
         s  = 2'(j);
         ti = (s == ASC_SRC_T1) ? 1 : ((s == ASC_SRC_T0) ? 0 : 2);
         wr_reg(ASC_REG_CTRL, {10'h000, s, j[0], 3'b010});
         repeat (6) @(posedge clk);
         wr_reg(ASC_REG_CTRL, {10'h000, s, j[0], 3'b011});
         fire((ti + 1) % 3);
         repeat (30) @(posedge clk);
         exp_cv.push_back(exp_rec(ASC_SHT_4, 12'h001 << ch, r[2], r[2] & ~r[3]));
         fire(ti);
         wait_done;
      end
      $display("test timer sources done");
      wr_reg(ASC_REG_CTRL, 16'h0002);
      wr_reg(ASC_REG_CTRL, 16'h0006);
      repeat (40) @(posedge clk);
      wr_reg(ASC_REG_CTRL, 16'h0002);
      wr_reg(ASC_REG_CTRL, 16'h0005);
      repeat (40) @(posedge clk);
      wr_reg(ASC_REG_CTRL, 16'h0001);
      snap_chk({ae, 1'b0, r[0], r[1], r[2] & ~r[3], r[4], r[5], r[6]});
      rd_reg(ASC_REG_STATUS, 16'h0000);
      $display("test refusals done");
      repeat (10) @(posedge clk);
      if (exp_cv.size() != 0 || exp_rd.size() != 0 || exp_pt.size() != 0) chk(66'h1, 66'h0, "pending results");
      complete_run;
   end
endmodule
`default_nettype wire
